// File: rtl/frbc_pkg.sv
// Package: constants for the frequency ramp and brake control block
// -----------------------------------------------------------------------------
// Contract
// - Increment select sets ramp time range, step
// - Accel time spans 0 Hz to reference
// - Decel time spans reference down to 0 Hz
// - Alternate times apply only under second select
// - Alternate decel code 9999 reuses alternate accel
// - Reference frequency 1 to 400 Hz, default 60
// - Pattern A times refer to rated frequency
// - Pattern A above rated: quadratic time law
// - Zero ramp time gives 0.04 s ramp
// - Thermal current 0 to 500 A, zero disables
// - Alternate thermal under second select, 9999 off
// - Two smallest ratings default to 85 percent
// - Brake starts at entry frequency, default 3 Hz
// - Brake holds 0 to 10 s, default 0.5
// - Brake voltage 0 to 30 percent, default 6
// - Constant-torque motor moves factory voltage to 4
// - Start threshold 0 to 60 Hz, default 0.5
// - No start while command below start threshold
// - Threshold under lower limit starts at limit
// - Running output never below lower limit
// - Rated frequency programmable, default 60 Hz
// -----------------------------------------------------------------------------
package frbc_pkg;
	// -------------------------------------------------------------------------
	// Widths and timing
	// -------------------------------------------------------------------------
	localparam int FW              = 16;
	localparam int TW              = 19;
	localparam int AW              = 48;
	localparam int FREQ_SCALE      = 100;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int TICK_PERIOD_NS  = 10_000_000;
	localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_MS         = 10;
	localparam int ZERO_RAMP_MS    = 40;
	localparam int ZERO_RAMP_TICKS = ZERO_RAMP_MS / TICK_MS;
	localparam int TIME_COARSE_MUL = 10;
	localparam int S_DEN           = 9;
	localparam int S_SQ            = 4;
	localparam int SMALL_RATINGS   = 2;
	localparam int SMALL_PCT       = 85;
	// -------------------------------------------------------------------------
	// Ranges and reset values (frequency 0.01 Hz, time in ticks or raw units)
	// -------------------------------------------------------------------------
	localparam logic [15:0] REF_MIN      = 16'(1 * FREQ_SCALE);
	localparam logic [15:0] REF_MAX      = 16'(400 * FREQ_SCALE);
	localparam logic [15:0] REF_DEF      = 16'(60 * FREQ_SCALE);
	localparam logic [15:0] RATED_DEF    = 16'(60 * FREQ_SCALE);
	localparam logic [15:0] LIMIT_MAX    = 16'(120 * FREQ_SCALE);
	localparam logic [15:0] ENTRY_DEF    = 16'(3 * FREQ_SCALE);
	localparam logic [15:0] START_MAX    = 16'(60 * FREQ_SCALE);
	localparam logic [15:0] START_DEF    = 16'(FREQ_SCALE / 2);
	localparam logic [15:0] HOLD_MAX     = 16'(10_000 / TICK_MS);
	localparam logic [15:0] HOLD_DEF     = 16'(500 / TICK_MS);
	localparam logic [15:0] TIME_MAX     = 16'(36000);
	localparam logic [15:0] TIME_DEF     = 16'(50);
	localparam logic [15:0] CURRENT_MAX  = 16'(500 * FREQ_SCALE);
	localparam logic [15:0] CODE_OFF     = 16'(9999);
	localparam logic [7:0]  VOLT_MAX     = 8'h1E;
	localparam logic [7:0]  VOLT_DEF     = 8'h06;
	localparam logic [7:0]  VOLT_CT      = 8'h04;
	localparam logic [1:0]  SHAPE_A      = 2'h1;
	localparam logic        MOTOR_CT     = 1'b1;
	// -------------------------------------------------------------------------
	// Register map (byte addresses) and fields
	// -------------------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_FREQ_CMD  = 8'h04;
	localparam logic [7:0] OFF_ACCEL     = 8'h08;
	localparam logic [7:0] OFF_DECEL     = 8'h0C;
	localparam logic [7:0] OFF_ALT_ACC   = 8'h10;
	localparam logic [7:0] OFF_ALT_DEC   = 8'h14;
	localparam logic [7:0] OFF_REF       = 8'h18;
	localparam logic [7:0] OFF_RATED     = 8'h1C;
	localparam logic [7:0] OFF_LOWER     = 8'h20;
	localparam logic [7:0] OFF_START     = 8'h24;
	localparam logic [7:0] OFF_ENTRY     = 8'h28;
	localparam logic [7:0] OFF_HOLD      = 8'h2C;
	localparam logic [7:0] OFF_VOLT      = 8'h30;
	localparam logic [7:0] OFF_THERM     = 8'h34;
	localparam logic [7:0] OFF_ALT_THERM = 8'h38;
	localparam logic [7:0] OFF_STATUS    = 8'h3C;
	localparam logic [7:0] OFF_OUT_FREQ  = 8'h40;
	localparam int CTRL_INC_BIT   = 0;
	localparam int CTRL_SHAPE_LSB = 1;
	localparam int CTRL_MOTOR_BIT = 3;
endpackage

// File: rtl/frbc_ramp_if.sv
// Interface: ramp accumulator request and step pulse
`timescale 1ns/1ns
interface frbc_ramp_if;
	logic                    tick;
	logic                    clear;
	logic [frbc_pkg::AW-1:0] inc;
	logic [frbc_pkg::AW-1:0] thr;
	logic                    step;
	modport ctrl (output tick, output clear, output inc, output thr, input step);
	modport gen  (input tick, input clear, input inc, input thr, output step);
endinterface

// File: rtl/frbc_sync.sv
// Module: two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module frbc_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // frbc_sync

// File: rtl/frbc_ramp.sv
// Module: ramp accumulator that turns a rate into unit frequency steps
`timescale 1ns/1ns
module frbc_ramp (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Request and step
	frbc_ramp_if.gen  rif
);
	import frbc_pkg::*;

	logic [AW-1:0] acc_q;
	logic [AW-1:0] acc_d;
	logic          hit;

	// Adds inc per tick and drains one threshold per clock, so many steps
	// can come out of one tick without a divider
	assign hit = acc_q >= rif.thr;

	always_comb
	begin
		acc_d = acc_q - (hit ? rif.thr : '0) + (rif.tick ? rif.inc : '0);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_q    <= '0;
			rif.step <= 1'b0;
		end
		else
		begin
			acc_q    <= rif.clear ? '0 : acc_d;
			rif.step <= hit && !rif.clear;
		end
	end

	step_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		rif.step |-> $past(acc_q >= rif.thr) && !$past(rif.clear)) else $error("step without threshold");
endmodule // frbc_ramp

// File: rtl/frbc_top.sv
// Module: output frequency ramp, start gating, DC brake and thermal settings
`timescale 1ns/1ns
module frbc_top #(
	parameter int TICK_CYCLES        = frbc_pkg::TICK_CYCLES,
	parameter int RATED_CURRENT      = 1000,
	parameter int DRIVE_RATING_INDEX = 0
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Drive pins
	input  wire logic                  start_in,
	input  wire logic                  second_set_select,
	// Power stage
	output logic      [frbc_pkg::FW-1:0] out_freq,
	output logic                       out_enable,
	output logic                       brake_active,
	output logic      [7:0]            brake_level,
	output logic      [15:0]           thermal_trip_current,
	output logic                       thermal_protect_enable
);
	import frbc_pkg::*;

	typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_DECEL, ST_BRAKE} frbc_state_type;

	localparam int TCW = $clog2(TICK_CYCLES + 1);
	localparam int THERMAL_RST_INT = (DRIVE_RATING_INDEX < SMALL_RATINGS) ?
		RATED_CURRENT * SMALL_PCT / FREQ_SCALE : RATED_CURRENT;
	localparam logic [15:0] THERMAL_RST = 16'(THERMAL_RST_INT);

	// -------------------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------------------
	function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v < {16'h0000, lo})
			return lo;
		else if (v > {16'h0000, hi})
			return hi;
		else
			return v[15:0];
	endfunction

	// Ramp time in ticks; coarse units are ten ticks each
	function automatic logic [TW-1:0] time_ticks(input logic [15:0] raw, input logic fine);
		if (raw == 16'h0000)
			return TW'(ZERO_RAMP_TICKS);
		else if (fine)
			return TW'(raw);
		else
			return TW'(TW'(raw) * TW'(TIME_COARSE_MUL));
	endfunction

	// -------------------------------------------------------------------------
	// Pins and tick
	// -------------------------------------------------------------------------
	logic [1:0]     pins_s;
	logic           start_s;
	logic           second_s;
	logic [TCW-1:0] tick_cnt_q;
	logic           tick;

	frbc_sync #(.W(2)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({start_in, second_set_select}),
		.q       (pins_s)
	);
	assign start_s  = pins_s[1];
	assign second_s = pins_s[0];

	assign tick = tick_cnt_q == TCW'(TICK_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 1'b1;
	end

	// -------------------------------------------------------------------------
	// Settings registers
	// -------------------------------------------------------------------------
	logic        inc_sel_q;
	logic [1:0]  shape_q;
	logic        motor_q;
	logic [15:0] freq_cmd_q;
	logic [15:0] accel_q;
	logic [15:0] decel_q;
	logic [15:0] alt_accel_q;
	logic [15:0] alt_decel_q;
	logic [15:0] ref_q;
	logic [15:0] rated_q;
	logic [15:0] lower_q;
	logic [15:0] start_thr_q;
	logic [15:0] entry_q;
	logic [15:0] hold_q;
	logic [7:0]  volt_q;
	logic        volt_factory_q;
	logic [15:0] therm_q;
	logic [15:0] alt_therm_q;
	logic        wr_en;
	logic        hit;
	logic [31:0] rd_data;
	logic [31:0] prdata_q;
	frbc_state_type state_q;
	logic [FW-1:0]  freq_q;

	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_q;

	always_comb
	begin
		hit     = 1'b1;
		rd_data = '0;
		if (paddr == OFF_CTRL)
			rd_data = 32'({motor_q, shape_q, inc_sel_q});
		else if (paddr == OFF_FREQ_CMD)
			rd_data = 32'(freq_cmd_q);
		else if (paddr == OFF_ACCEL)
			rd_data = 32'(accel_q);
		else if (paddr == OFF_DECEL)
			rd_data = 32'(decel_q);
		else if (paddr == OFF_ALT_ACC)
			rd_data = 32'(alt_accel_q);
		else if (paddr == OFF_ALT_DEC)
			rd_data = 32'(alt_decel_q);
		else if (paddr == OFF_REF)
			rd_data = 32'(ref_q);
		else if (paddr == OFF_RATED)
			rd_data = 32'(rated_q);
		else if (paddr == OFF_LOWER)
			rd_data = 32'(lower_q);
		else if (paddr == OFF_START)
			rd_data = 32'(start_thr_q);
		else if (paddr == OFF_ENTRY)
			rd_data = 32'(entry_q);
		else if (paddr == OFF_HOLD)
			rd_data = 32'(hold_q);
		else if (paddr == OFF_VOLT)
			rd_data = 32'(volt_q);
		else if (paddr == OFF_THERM)
			rd_data = 32'(therm_q);
		else if (paddr == OFF_ALT_THERM)
			rd_data = 32'(alt_therm_q);
		else if (paddr == OFF_STATUS)
			rd_data = 32'({thermal_protect_enable, brake_active, second_s, state_q});
		else if (paddr == OFF_OUT_FREQ)
			rd_data = 32'(freq_q);
		else
			hit = 1'b0;
	end

	// Read data is caught in the setup cycle so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (psel && !penable && !pwrite)
			prdata_q <= rd_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			inc_sel_q      <= 1'b0;
			shape_q        <= '0;
			motor_q        <= 1'b0;
			freq_cmd_q     <= '0;
			accel_q        <= TIME_DEF;
			decel_q        <= TIME_DEF;
			alt_accel_q    <= TIME_DEF;
			alt_decel_q    <= CODE_OFF;
			ref_q          <= REF_DEF;
			rated_q        <= RATED_DEF;
			lower_q        <= '0;
			start_thr_q    <= START_DEF;
			entry_q        <= ENTRY_DEF;
			hold_q         <= HOLD_DEF;
			volt_q         <= VOLT_DEF;
			volt_factory_q <= 1'b1;
			therm_q        <= THERMAL_RST;
			alt_therm_q    <= CODE_OFF;
		end
		else if (wr_en && hit)
		begin
			if (paddr == OFF_CTRL)
			begin
				inc_sel_q <= pwdata[CTRL_INC_BIT];
				shape_q   <= pwdata[CTRL_SHAPE_LSB +: 2];
				motor_q   <= pwdata[CTRL_MOTOR_BIT];
				if (pwdata[CTRL_MOTOR_BIT] == MOTOR_CT && motor_q != MOTOR_CT && volt_factory_q)
				begin
					volt_q         <= VOLT_CT;
					volt_factory_q <= 1'b0;
				end
			end
			else if (paddr == OFF_FREQ_CMD)
				freq_cmd_q <= clamp16(pwdata, '0, REF_MAX);
			else if (paddr == OFF_ACCEL)
				accel_q <= clamp16(pwdata, '0, TIME_MAX);
			else if (paddr == OFF_DECEL)
				decel_q <= clamp16(pwdata, '0, TIME_MAX);
			else if (paddr == OFF_ALT_ACC)
				alt_accel_q <= clamp16(pwdata, '0, TIME_MAX);
			else if (paddr == OFF_ALT_DEC)
				alt_decel_q <= (pwdata == 32'(CODE_OFF)) ? CODE_OFF : clamp16(pwdata, '0, TIME_MAX);
			else if (paddr == OFF_REF)
				ref_q <= clamp16(pwdata, REF_MIN, REF_MAX);
			else if (paddr == OFF_RATED)
				rated_q <= clamp16(pwdata, REF_MIN, REF_MAX);
			else if (paddr == OFF_LOWER)
				lower_q <= clamp16(pwdata, '0, LIMIT_MAX);
			else if (paddr == OFF_START)
				start_thr_q <= clamp16(pwdata, '0, START_MAX);
			else if (paddr == OFF_ENTRY)
				entry_q <= clamp16(pwdata, '0, LIMIT_MAX);
			else if (paddr == OFF_HOLD)
				hold_q <= clamp16(pwdata, '0, HOLD_MAX);
			else if (paddr == OFF_VOLT)
			begin
				volt_q         <= 8'(clamp16(pwdata, '0, 16'(VOLT_MAX)));
				volt_factory_q <= 1'b0;
			end
			else if (paddr == OFF_THERM)
				therm_q <= clamp16(pwdata, '0, CURRENT_MAX);
			else if (paddr == OFF_ALT_THERM)
				alt_therm_q <= (pwdata == 32'(CODE_OFF)) ? CODE_OFF : clamp16(pwdata, '0, CURRENT_MAX);
		end
	end

	// -------------------------------------------------------------------------
	// Ramp rate selection
	// -------------------------------------------------------------------------
	logic [TW-1:0] accel_ticks;
	logic [TW-1:0] decel_ticks;
	logic [TW-1:0] t_act;
	logic [15:0]   eff_cmd;
	logic [15:0]   target;
	logic          start_ok;
	logic          up;
	logic          down;
	logic          dir_q;
	frbc_ramp_if   rif ();

	always_comb
	begin
		accel_ticks = time_ticks(second_s ? alt_accel_q : accel_q, inc_sel_q);
		if (!second_s)
			decel_ticks = time_ticks(decel_q, inc_sel_q);
		else if (alt_decel_q == CODE_OFF)
			decel_ticks = time_ticks(alt_accel_q, inc_sel_q);
		else
			decel_ticks = time_ticks(alt_decel_q, inc_sel_q);
	end

	// A command below the lower limit is lifted to it
	assign eff_cmd  = (freq_cmd_q < lower_q) ? lower_q : freq_cmd_q;
	assign start_ok = start_s && (eff_cmd >= start_thr_q);
	assign target   = (state_q == ST_RUN) ? eff_cmd : '0;
	assign up       = (state_q == ST_RUN) && (freq_q < target);
	assign down     = (state_q == ST_RUN || state_q == ST_DECEL) && (freq_q > target);
	assign t_act    = up ? accel_ticks : decel_ticks;

	// Rate is inc/thr LSBs per tick; pattern A uses the rated frequency as
	// reference and above it slows so the total time follows the quadratic law
	always_comb
	begin
		rif.tick  = tick && (up || down);
		rif.clear = !(up || down) || (up != dir_q);
		if (shape_q == SHAPE_A)
		begin
			rif.inc = AW'(S_DEN) * AW'(rated_q) * AW'(rated_q);
			if (freq_q >= rated_q)
				rif.thr = AW'(2 * S_SQ) * AW'(freq_q) * AW'(t_act);
			else
				rif.thr = AW'(S_DEN) * AW'(rated_q) * AW'(t_act);
		end
		else
		begin
			rif.inc = AW'(ref_q);
			rif.thr = AW'(t_act);
		end
	end

	frbc_ramp u_ramp (
		.pclk    (pclk),
		.presetn (presetn),
		.rif     (rif)
	);

	// -------------------------------------------------------------------------
	// Run, decelerate and brake sequence
	// -------------------------------------------------------------------------
	logic [15:0] hold_cnt_q;
	logic [15:0] brake_seen_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dir_q <= 1'b0;
		else
			dir_q <= up;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q    <= ST_STOP;
			freq_q     <= '0;
			hold_cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				ST_STOP:
				begin
					freq_q <= '0;
					if (start_ok)
					begin
						state_q <= ST_RUN;
						freq_q  <= (lower_q > start_thr_q) ? lower_q : start_thr_q;
					end
				end
				ST_RUN:
				begin
					if (!start_s)
						state_q <= ST_DECEL;
					else if (freq_q < lower_q)
						freq_q <= lower_q;
					else if (rif.step && up)
						freq_q <= freq_q + 1'b1;
					else if (rif.step && down)
						freq_q <= freq_q - 1'b1;
				end
				ST_DECEL:
				begin
					if (freq_q <= entry_q)
					begin
						freq_q     <= '0;
						hold_cnt_q <= '0;
						state_q    <= (hold_q != '0) ? ST_BRAKE : ST_STOP;
					end
					else if (start_ok)
						state_q <= ST_RUN;
					else if (rif.step && down)
						freq_q <= freq_q - 1'b1;
				end
				ST_BRAKE:
				begin
					freq_q <= '0;
					if (tick)
					begin
						if (hold_cnt_q + 1'b1 >= hold_q)
							state_q <= ST_STOP;
						else
							hold_cnt_q <= hold_cnt_q + 1'b1;
					end
				end
				default:
					state_q <= ST_STOP;
			endcase
		end
	end

	// Thermal setting is registered so the power stage sees a clean word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			thermal_trip_current <= THERMAL_RST;
		else if (second_s && alt_therm_q != CODE_OFF)
			thermal_trip_current <= alt_therm_q;
		else
			thermal_trip_current <= therm_q;
	end

	assign thermal_protect_enable = thermal_trip_current != '0;
	assign out_freq     = freq_q;
	assign out_enable   = state_q == ST_RUN || state_q == ST_DECEL;
	assign brake_active = state_q == ST_BRAKE;
	assign brake_level  = brake_active ? volt_q : '0;

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			brake_seen_q <= '0;
		else if (state_q != ST_BRAKE)
			brake_seen_q <= '0;
		else if (tick)
			brake_seen_q <= brake_seen_q + 1'b1;
	end

	start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(out_enable) && $past(state_q) == ST_STOP |-> $past(eff_cmd >= start_thr_q) && $past(start_s))
		else $error("output started below threshold");

	lower_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_RUN && $past(state_q) == ST_RUN && $stable(lower_q) |-> freq_q >= lower_q)
		else $error("running output below lower limit");

	brake_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_DECEL && freq_q <= entry_q && hold_q != '0 |=> brake_active && out_freq == '0)
		else $error("brake not entered at entry frequency");

	brake_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(brake_active) && $stable(hold_q) |-> brake_seen_q == hold_q && state_q == ST_STOP)
		else $error("brake hold length wrong");

	stop_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_STOP && $past(state_q) == ST_STOP |-> out_freq == '0 && !out_enable && brake_level == '0)
		else $error("output present while stopped");

	zero_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
		!second_s && accel_q == '0 |-> accel_ticks == TW'(ZERO_RAMP_TICKS))
		else $error("zero ramp time not four ticks");

	alt_decel_a: assert property (@(posedge pclk) disable iff (!presetn)
		second_s && alt_decel_q == CODE_OFF && !inc_sel_q && alt_accel_q != '0
		|-> decel_ticks == TW'(alt_accel_q) * TW'(TIME_COARSE_MUL))
		else $error("alternate decel not taken from accel");

	volt_auto_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == OFF_CTRL && pwdata[CTRL_MOTOR_BIT] && !motor_q && volt_factory_q
		|=> volt_q == VOLT_CT ##1 $stable(volt_q))
		else $error("brake voltage not moved to 4 percent");

	thermal_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		$stable(second_s) && $stable(alt_therm_q) && $stable(therm_q) && !second_s
		|-> thermal_trip_current == therm_q)
		else $error("alternate thermal current leaked");

	ref_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		ref_q >= REF_MIN && ref_q <= REF_MAX)
		else $error("reference frequency out of range");
endmodule // frbc_top

// File: sim/frbc_stage_model.sv
// Power stage model: watches the drive outputs and times each DC brake episode
`timescale 1ns/1ns
module frbc_stage_model (
	// Clock
	input  wire logic                    pclk,
	// Drive outputs
	input  wire logic [frbc_pkg::FW-1:0] out_freq,
	input  wire logic                    out_enable,
	input  wire logic                    brake_active,
	input  wire logic [7:0]              brake_level,
	// Observations
	output int                           brake_cycles,
	output logic      [7:0]              brake_volts
);
	int run_q = 0;
	// Only a finished episode is reported, so a stuck brake never looks short
	always @(posedge pclk)
		if (brake_active)
		begin
			run_q <= run_q + 1;
			brake_volts <= brake_level;
		end
		else if (run_q != 0)
		begin
			brake_cycles <= run_q;
			run_q <= 0;
		end
endmodule // frbc_stage_model

// File: sim/frbc_top_tb.sv
// Testbench: APB settings, ramp timing, start gating and DC brake
`timescale 1ns/1ns
module frbc_top_tb;
	import frbc_pkg::*;
	// Short ticks keep every ramp within a few thousand cycles
	localparam int TK = 400;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start_in = 0, second_set_select = 0;
	logic pready, pslverr, out_enable, brake_active, thermal_protect_enable, ev;
	logic [7:0] paddr = 8'h00, brake_level, bv;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [15:0] thermal_trip_current;
	logic [FW-1:0] out_freq, tf;
	int miscompares = 0, checks_done = 0, cyc, bc;
	logic [7:0] ra [7] = '{OFF_REF, OFF_RATED, OFF_START, OFF_ENTRY, OFF_HOLD, OFF_VOLT, OFF_THERM};
	logic [15:0] rx [7] = '{REF_DEF, RATED_DEF, START_DEF, ENTRY_DEF, HOLD_DEF, 16'(VOLT_DEF), 16'(10 * SMALL_PCT)};
	always #50 pclk = ~pclk;
	frbc_top #(.TICK_CYCLES(TK), .RATED_CURRENT(1000), .DRIVE_RATING_INDEX(0)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_in, .second_set_select, .out_freq,
		.out_enable, .brake_active, .brake_level, .thermal_trip_current, .thermal_protect_enable);
	frbc_stage_model stage (.pclk, .out_freq, .out_enable, .brake_active, .brake_level, .brake_cycles(bc),
		.brake_volts(bv));
	task conclude;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %0h want %0h", $time, seen, exp);
		end
	endtask
	task hang;
		miscompares++;
		$display("BAD %0t wait ran out", $time);
		conclude;
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang;
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Kind 0: output at target, 1: brake applied, 2: fully stopped
	task waitfor(input int k);
		cyc = 0;
		while (!(k == 0 ? out_freq === tf : k == 1 ? brake_active === 1'b1 : {out_enable, brake_active} === 2'b00))
		begin
			@(posedge pclk);
			cyc++;
			if (cyc > 20000) hang;
		end
	endtask
	task rng(input int lo, input int hi);
		chk(32'(cyc >= lo * TK && cyc <= hi * TK), 32'h1);
	endtask
	task run(input logic [FW-1:0] f);
		tf = f;
		start_in <= 1'b1;
		waitfor(0);
	endtask
	task halt;
		start_in <= 1'b0;
		waitfor(1);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 7; i++)
		begin
			xfer(0, ra[i], 0);
			chk(rv, 32'(rx[i]));
		end
		chk(32'(thermal_trip_current), 32'(rx[6]));
		xfer(0, 8'h44, 0);
		chk(32'(ev), 32'h1);
		xfer(1, OFF_THERM, 0);
		// The trip word is registered one edge after the setting
		@(posedge pclk);
		chk(32'(thermal_protect_enable), 32'h0);
		xfer(1, OFF_ALT_THERM, 32'h1F4);
		second_set_select <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(32'(thermal_trip_current), 32'h1F4);
		xfer(1, OFF_ALT_THERM, 32'(CODE_OFF));
		@(posedge pclk);
		chk(32'(thermal_trip_current), 32'h0);
		second_set_select <= 1'b0;
		done("thermal");
		xfer(1, OFF_CTRL, 32'h9);
		xfer(0, OFF_VOLT, 0);
		chk(rv, 32'(VOLT_CT));
		xfer(1, OFF_REF, 32'h3E8);
		xfer(1, OFF_ACCEL, 32'hA);
		xfer(1, OFF_DECEL, 32'hA);
		xfer(1, OFF_HOLD, 32'h5);
		xfer(1, OFF_FREQ_CMD, 32'h14);
		start_in <= 1'b1;
		repeat (20) @(posedge pclk);
		chk(32'(out_enable), 32'h0);
		xfer(1, OFF_FREQ_CMD, 32'h3E8);
		run(16'h3E8);
		rng(8, 11);
		halt;
		rng(6, 9);
		chk(32'(brake_level), 32'(VOLT_CT));
		waitfor(2);
		@(posedge pclk);
		chk(32'(bc >= 4 * TK && bc <= 5 * TK + 4), 32'h1);
		chk(32'(bv), 32'(VOLT_CT));
		chk(32'(out_freq), 32'h0);
		done("linear");
		second_set_select <= 1'b1;
		xfer(1, OFF_ALT_ACC, 32'h14);
		run(16'h3E8);
		rng(18, 21);
		halt;
		rng(13, 16);
		waitfor(2);
		second_set_select <= 1'b0;
		done("alternate");
		xfer(1, OFF_CTRL, 32'h8);
		xfer(1, OFF_ACCEL, 32'h1);
		xfer(1, OFF_DECEL, 32'h1);
		run(16'h3E8);
		rng(8, 11);
		halt;
		waitfor(2);
		xfer(1, OFF_ACCEL, 32'h0);
		run(16'h3E8);
		rng(0, 5);
		halt;
		waitfor(2);
		done("coarse");
		xfer(1, OFF_LOWER, 32'h1F4);
		xfer(1, OFF_FREQ_CMD, 32'h0);
		run(16'h1F4);
		repeat (100) @(posedge pclk);
		chk(32'(out_enable), 32'h1);
		chk(32'(out_freq), 32'h1F4);
		xfer(0, OFF_STATUS, 0);
		chk(rv, 32'h1);
		xfer(0, OFF_OUT_FREQ, 0);
		chk(rv, 32'h1F4);
		done("limits");
		// Pattern A with rated 5 Hz: 5 to 10 Hz takes 4/9*T*3, T = 10 ticks
		xfer(1, OFF_CTRL, 32'hB);
		xfer(1, OFF_ACCEL, 32'hA);
		xfer(1, OFF_DECEL, 32'hA);
		xfer(1, OFF_RATED, 32'h1F4);
		xfer(1, OFF_FREQ_CMD, 32'h3E8);
		run(16'h3E8);
		rng(12, 15);
		// Down to the brake: 13.3 ticks above rated, 4 ticks at rated/T below it
		halt;
		rng(17, 19);
		done("pattern");
		conclude;
	end
endmodule // frbc_top_tb
